/* pkg/tmr_consts.svh */
// Register offsets, field positions, reset values and encodings of the capture/compare timer
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

`define ADDR_W            4
`define ADDR_COUNT        4'h0
`define ADDR_CC0          4'h1
`define ADDR_CC1          4'h2
`define ADDR_PRESCALE     4'h3
`define ADDR_MODE         4'h4
`define ADDR_CAPCTL       4'h5

`define CNT_MAX           16'hffff
`define CNT_ZERO          16'h0000

// Mode control fields
`define MODE_SEL_HI       3
`define MODE_SEL_LO       2
`define MODE_TOGGLE_BIT   1
`define MODE_OVF_BIT      0
`define MODE_STOP         2'h0
`define MODE_FREE         2'h1
`define MODE_CLEAR_START  2'h2

// Capture control fields
`define CAP_CC0_CAPTURE   0
`define CAP_REVERSE       1
`define CAP_CC1_CAPTURE   2

// Prescale / edge select fields
`define PS_EDGE2_HI       6
`define PS_EDGE2_LO       5
`define PS_EDGE1_HI       5'h5
`define PS_EDGE1_LO       4
`define PS_CLK_HI         1
`define PS_CLK_LO         0
`define EDGE_FALL         2'h0
`define EDGE_RISE         2'h1
`define EDGE_BOTH         2'h3
`define CLK_SEL_EDGE1     2'h3

`define RESET_BYTE        8'h00
`define RESET_WORD        16'h0000

`endif

/* pkg/tmr_pkg.sv */
// Types shared by the capture/compare timer
package tmr_pkg;
    typedef logic [15:0] word_t;
    typedef logic [7:0]  byte_t;
    typedef logic [1:0]  edge_sel_t;
endpackage

/* design/edge_detect.sv */
// Edge detector for one timer input pin with selectable polarity
`timescale 1ns/1ns
`default_nettype none
`include "tmr_consts.svh"
module edge_detect
    import tmr_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    input  wire logic              pin_i,
    input  wire tmr_pkg::edge_sel_t sel_i,
    output logic                   valid_o,
    output logic                   reverse_o
);
    logic prev;
    logic rise;
    logic fall;

    // Previous level of the pin for edge comparison
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev <= 1'b0;
        end else begin
            prev <= pin_i;
        end
    end

    assign rise = pin_i & ~prev;
    assign fall = ~pin_i & prev;

    // Valid edge per selection; reverse is the opposite polarity edge, and nothing when both edges are selected
    always_comb begin
        unique case (sel_i)
            `EDGE_FALL: begin
                valid_o   = fall;
                reverse_o = rise;
            end
            `EDGE_RISE: begin
                valid_o   = rise;
                reverse_o = fall;
            end
            `EDGE_BOTH: begin
                valid_o   = rise | fall;
                reverse_o = 1'b0;
            end
            default: begin
                valid_o   = 1'b0; // Prohibited code detects nothing
                reverse_o = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

/* design/timer_capture_compare_16bit.sv */
// 16-bit up-counter with two capture/compare registers, timer output and interrupts
//
// Behaviour
// - Mode 01 counts up every count clock, never cleared by compare match.
// - After FFFF the next count sets overflow flag and wraps to 0000.
// - Clear-and-start toggles output on edge clear and on a compare match, unless both registers match at once.
// - Reverse-phase capture loads register zero on opposite first-input edge, no interrupt.
// - With reverse-phase capture, second-input edge still raises interrupt zero, no capture.
// - Register one in capture mode latches count on first-input valid edge.
// - Register zero capture trigger is second-input valid edge, or opposite first-input edge in reverse phase.
// - Compare match raises matching interrupt and does not clear the counter.
// - Second-input edge field: 00 falling, 01 rising, 11 both; 10 prohibited.
// - Free-running, both capturing: output holds unless toggle bit set.
// - Free-running, both comparing: output toggles on each match unless both match together, interrupt raised.
// - Free-running, register one capturing: first-input edge latches and interrupts one.
// - Both capturing, only second-input edges: register one gets no capture.
// - Clear-and-start, register one capturing: edge captures, clears, toggles output.
// - Mode 10 is clear-and-start: first-input edge clears counter, counting resumes.
// - Mode 00 stops counting and initialises the counter.
// - Capture of old count completes before the counter is cleared.
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "tmr_consts.svh"
module timer_capture_compare_16bit
    import tmr_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 arst_n_i,
    input  wire logic [`ADDR_W-1:0]   addr_i,
    input  wire tmr_pkg::word_t       wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output tmr_pkg::word_t            rdata_o,
    input  wire logic                 first_timer_input_i,
    input  wire logic                 second_timer_input_i,
    input  wire logic                 count_tick_i,
    output logic                      timer_output_o,
    output logic                      interrupt_zero_o,
    output logic                      interrupt_one_o
);
    import tmr_pkg::*;

    word_t  timer_count_value;
    word_t  capture_compare_zero;
    word_t  capture_compare_one;
    byte_t  prescale_edge_select;
    byte_t  timer_mode_control;
    byte_t  capture_control;
    logic   overflow_flag;

    logic   first_valid;
    logic   first_reverse;
    logic   second_valid;
    logic   second_unused;
    logic   count_en;
    logic   free_mode;
    logic   clr_mode;
    logic   cc0_cap;
    logic   cc1_cap;
    logic   reverse_sel;
    logic   match0;
    logic   match1;
    logic   cap0_evt;
    logic   cap1_evt;
    logic   next_irq0;
    logic   next_irq1;
    logic   next_toggle;
    logic   clear_evt;
    logic   wr_cc0;
    logic   wr_cc1;

    // Write decode used for several registers
    function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    edge_detect u_first (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .pin_i     (first_timer_input_i),
        .sel_i     (prescale_edge_select[`PS_EDGE1_HI:`PS_EDGE1_LO]),
        .valid_o   (first_valid),
        .reverse_o (first_reverse)
    );

    // Code 10 detects nothing inside the detector
    edge_detect u_second (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .pin_i     (second_timer_input_i),
        .sel_i     (prescale_edge_select[`PS_EDGE2_HI:`PS_EDGE2_LO]),
        .valid_o   (second_valid),
        .reverse_o (second_unused)
    );

    // Mode decode
    assign free_mode   = timer_mode_control[`MODE_SEL_HI:`MODE_SEL_LO] == `MODE_FREE;
    assign clr_mode    = timer_mode_control[`MODE_SEL_HI:`MODE_SEL_LO] == `MODE_CLEAR_START;
    assign cc0_cap     = capture_control[`CAP_CC0_CAPTURE];
    assign cc1_cap     = capture_control[`CAP_CC1_CAPTURE];
    assign reverse_sel = capture_control[`CAP_REVERSE];
    assign count_en    = (free_mode | clr_mode) & count_tick_i;
    assign wr_cc0      = wr_i & hit(addr_i, `ADDR_CC0);
    assign wr_cc1      = wr_i & hit(addr_i, `ADDR_CC1);

    // Compare matches, sampled on count clocks only
    assign match0 = count_en & ~cc0_cap & (timer_count_value == capture_compare_zero);
    assign match1 = count_en & ~cc1_cap & (timer_count_value == capture_compare_one);

    // Capture triggers; reverse phase only steers register zero
    assign cap0_evt = (free_mode | clr_mode) & cc0_cap &
                      (reverse_sel ? first_reverse : second_valid);
    assign cap1_evt = (free_mode | clr_mode) & cc1_cap & first_valid;
    assign clear_evt = clr_mode & first_valid;

    // Interrupt causes
    always_comb begin
        next_irq0 = match0;
        if (cc0_cap & (free_mode | clr_mode)) begin
            if (reverse_sel) begin
                next_irq0 = second_valid;
            end else begin
                next_irq0 = second_valid;
            end
        end
        next_irq1 = match1 | cap1_evt;
    end

    // Output toggle causes
    always_comb begin
        next_toggle = match0 | match1;
        if (clear_evt) begin
            next_toggle = 1'b1;
        end
        if (free_mode & first_valid & timer_mode_control[`MODE_TOGGLE_BIT]) begin
            next_toggle = 1'b1;
        end
        if (match0 & match1) begin
            next_toggle = 1'b0; // Two matches cancel
        end
    end

    // Counter; capture below reads the old value in the same edge
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            timer_count_value <= `RESET_WORD;
        end else if (!(free_mode | clr_mode)) begin
            timer_count_value <= `CNT_ZERO;
        end else if (clear_evt) begin
            timer_count_value <= `CNT_ZERO;
        end else if (count_en) begin
            timer_count_value <= timer_count_value + 16'h0001;
        end
    end

    // Overflow flag; set wins over a clearing write
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            overflow_flag <= 1'b0;
        end else if (count_en & ~clear_evt & (timer_count_value == `CNT_MAX)) begin
            overflow_flag <= 1'b1;
        end else if (wr_i & hit(addr_i, `ADDR_MODE) & ~wdata_i[`MODE_OVF_BIT]) begin
            overflow_flag <= 1'b0;
        end
    end

    // Capture/compare register zero; capture beats a software write
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            capture_compare_zero <= `RESET_WORD;
        end else if (cap0_evt) begin
            capture_compare_zero <= timer_count_value;
        end else if (wr_cc0) begin
            capture_compare_zero <= wdata_i;
        end
    end

    // Capture/compare register one
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            capture_compare_one <= `RESET_WORD;
        end else if (cap1_evt) begin
            capture_compare_one <= timer_count_value;
        end else if (wr_cc1) begin
            capture_compare_one <= wdata_i;
        end
    end

    // Control registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prescale_edge_select <= `RESET_BYTE;
            timer_mode_control   <= `RESET_BYTE;
            capture_control      <= `RESET_BYTE;
        end else if (wr_i) begin
            if (hit(addr_i, `ADDR_PRESCALE)) begin
                prescale_edge_select <= wdata_i[7:0];
            end
            if (hit(addr_i, `ADDR_MODE)) begin
                timer_mode_control <= wdata_i[7:0];
            end
            if (hit(addr_i, `ADDR_CAPCTL)) begin
                capture_control <= wdata_i[7:0];
            end
        end
    end

    // Interrupt pulses, one clock per event
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            interrupt_zero_o <= 1'b0;
            interrupt_one_o  <= 1'b0;
        end else begin
            interrupt_zero_o <= next_irq0;
            interrupt_one_o  <= next_irq1;
        end
    end

    // Timer output; stopped mode holds the level
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            timer_output_o <= 1'b0;
        end else if (next_toggle) begin
            timer_output_o <= ~timer_output_o;
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= `RESET_WORD;
        end else if (rd_i) begin
            unique case (addr_i)
                `ADDR_COUNT:    rdata_o <= timer_count_value;
                `ADDR_CC0:      rdata_o <= capture_compare_zero;
                `ADDR_CC1:      rdata_o <= capture_compare_one;
                `ADDR_PRESCALE: rdata_o <= {8'h00, prescale_edge_select};
                `ADDR_MODE:     rdata_o <= {8'h00, timer_mode_control[7:1], overflow_flag};
                `ADDR_CAPCTL:   rdata_o <= {8'h00, capture_control};
                default:        rdata_o <= `RESET_WORD;
            endcase
        end else begin
            rdata_o <= `RESET_WORD;
        end
    end
endmodule
`default_nettype wire

/* dv/tcc_pins_model.sv */
// Pin and prescaler stand-in that drives the timer inputs
`timescale 1ns/1ns
`default_nettype none
module tcc_pins_model (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic tick_en_i,
    input  wire logic first_lvl_i,
    input  wire logic second_lvl_i,
    output logic      count_tick_o,
    output logic      first_pin_o,
    output logic      second_pin_o
);
    // Pins settle one clock after a request, never mid-cycle
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_tick_o <= 1'b0;
            first_pin_o  <= 1'b0;
            second_pin_o <= 1'b0;
        end else begin
            count_tick_o <= tick_en_i;
            first_pin_o  <= first_lvl_i;
            second_pin_o <= second_lvl_i;
        end
    end
endmodule
`default_nettype wire

/* dv/timer_capture_compare_16bit_asserts.sv */
// Port-level assertions for the capture/compare timer
`timescale 1ns/1ns
`default_nettype none
module tcc_checker
    import tmr_pkg::*;
(
    input wire logic           clk_i,
    input wire logic           arst_n_i,
    input wire logic [3:0]     addr_i,
    input wire logic           rd_i,
    input wire tmr_pkg::word_t rdata_o,
    input wire logic           first_timer_input_i,
    input wire logic           second_timer_input_i,
    input wire logic           count_tick_i,
    input wire logic           timer_output_o,
    input wire logic           interrupt_zero_o,
    input wire logic           interrupt_one_o
);
    logic [2:0] age_f;
    logic [2:0] age_a;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // Cycles since a tick or pin change; saturates so idle never wraps
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            age_f <= 3'h7;
            age_a <= 3'h7;
        end else begin
            age_f <= (count_tick_i || $changed(first_timer_input_i)) ? 3'h0
                   : age_f + {2'h0, age_f != 3'h7};
            age_a <= (count_tick_i || $changed(first_timer_input_i)
                   || $changed(second_timer_input_i)) ? 3'h0 : age_a + {2'h0, age_a != 3'h7};
        end
    end
    a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data not zero outside read slot");
    a_read_unmapped: assert property ($past(rd_i) && $past(addr_i) > 4'h5 |-> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_read_upper: assert property ($past(rd_i) && $past(addr_i) > 4'h2 |-> rdata_o[15:8] == 8'h00)
        else $error("byte register upper half not zero");
    a_irq0_pulse: assert property (interrupt_zero_o |=> !interrupt_zero_o)
        else $error("interrupt zero longer than one cycle");
    a_irq1_pulse: assert property (interrupt_one_o |=> !interrupt_one_o)
        else $error("interrupt one longer than one cycle");
    a_irq0_cause: assert property (interrupt_zero_o |-> age_a < 3'h5)
        else $error("interrupt zero without tick or edge");
    a_irq1_cause: assert property (interrupt_one_o |-> age_f < 3'h5)
        else $error("interrupt one without tick or edge");
    a_out_cause: assert property ($changed(timer_output_o) |-> age_f < 3'h5)
        else $error("timer output moved without cause");
endmodule
bind timer_capture_compare_16bit tcc_checker i_tcc_checker (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .first_timer_input_i(first_timer_input_i), .second_timer_input_i(second_timer_input_i),
    .count_tick_i(count_tick_i), .timer_output_o(timer_output_o),
    .interrupt_zero_o(interrupt_zero_o), .interrupt_one_o(interrupt_one_o));
`default_nettype wire

/* dv/timer_capture_compare_16bit_test.sv */
// Self-checking bench for the capture/compare timer
`timescale 1ns/1ns
`default_nettype none
`include "tmr_consts.svh"
module timer_capture_compare_16bit_test;
    import tmr_pkg::*;
    logic       clk_i = 1'b0;
    logic       arst_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    word_t      wdata_i = 16'h0000;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic       tick_en = 1'b0;
    logic       f_lvl = 1'b0;
    logic       s_lvl = 1'b0;
    logic       t_prev = 1'b0;
    logic       f_pin, s_pin, tick, t_out, irq0, irq1;
    word_t      rdata_o;
    int         mismatches = 0;
    int         n_compared = 0;
    int         n0 = 0;
    int         n1 = 0;
    int         nt = 0;
    always #25 clk_i = ~clk_i;
    timer_capture_compare_16bit i_timer_capture_compare_16bit (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .first_timer_input_i(f_pin),
        .second_timer_input_i(s_pin), .count_tick_i(tick), .timer_output_o(t_out),
        .interrupt_zero_o(irq0), .interrupt_one_o(irq1));
    tcc_pins_model i_tcc_pins_model (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .tick_en_i(tick_en), .first_lvl_i(f_lvl),
        .second_lvl_i(s_lvl), .count_tick_o(tick), .first_pin_o(f_pin), .second_pin_o(s_pin));
    // Event tallies; tests use differences so nothing needs clearing
    always @(posedge clk_i) begin
        t_prev <= t_out;
        if (irq0 === 1'b1) n0 <= n0 + 1;
        if (irq1 === 1'b1) n1 <= n1 + 1;
        if (t_out !== t_prev) nt <= nt + 1;
    end
    task automatic chk(input string n, input word_t s, input word_t e);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input word_t d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, output word_t v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask
    // Pin move then settle; capture lands a few clocks after the change
    task automatic pin(input bit sec, input logic lvl);
        @(posedge clk_i);
        if (sec) s_lvl <= lvl;
        else f_lvl <= lvl;
        repeat (8) @(posedge clk_i);
    endtask
    function automatic word_t near(input word_t v, input word_t a);
        return word_t'((v - a) >= 16'h0002 && (v - a) <= 16'h0008);
    endfunction
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic t_regs();
        word_t v;
        for (int i = 0; i < 8; i++) begin
            rreg(i[3:0], v);
            chk("reset", v, 16'h0000);
        end
        wreg(`ADDR_CC1, 16'habcd);
        rreg(`ADDR_CC1, v);
        chk("cc1", v, 16'habcd);
        wreg(`ADDR_COUNT, 16'h1234);
        rreg(`ADDR_COUNT, v);
        chk("count ro", v, 16'h0000);
        $display("done regs");
    endtask
    task automatic t_free();
        word_t a, v;
        int s0, s1, st;
        wreg(`ADDR_CC0, 16'h0100);
        wreg(`ADDR_CC1, 16'h0200);
        wreg(`ADDR_MODE, 16'h0004);
        tick_en <= 1'b1;
        rreg(`ADDR_COUNT, a);
        repeat (48) @(posedge clk_i);
        rreg(`ADDR_COUNT, v);
        chk("step", v - a, 16'h0032);
        s0 = n0;
        s1 = n1;
        st = nt;
        repeat (65600) @(posedge clk_i);
        chk("irq0", 16'(n0 - s0), 16'h0001);
        chk("irq1", 16'(n1 - s1), 16'h0001);
        chk("tog", 16'(nt - st), 16'h0002);
        rreg(`ADDR_MODE, v);
        chk("ovf", v, 16'h0005);
        wreg(`ADDR_MODE, 16'h0004);
        rreg(`ADDR_MODE, v);
        chk("ovf clr", v, 16'h0004);
        wreg(`ADDR_MODE, 16'h0000);
        rreg(`ADDR_COUNT, v);
        chk("stop", v, 16'h0000);
        $display("done free");
    endtask
    task automatic t_clear();
        word_t a, v;
        int s0, s1, st;
        wreg(`ADDR_PRESCALE, 16'h0010);
        wreg(`ADDR_CAPCTL, 16'h0004);
        wreg(`ADDR_MODE, 16'h0008);
        repeat (20) @(posedge clk_i);
        s0 = n0;
        s1 = n1;
        st = nt;
        rreg(`ADDR_COUNT, a);
        pin(1'b0, 1'b1);
        rreg(`ADDR_CC1, v);
        chk("cap", near(v, a), 16'h0001);
        rreg(`ADDR_COUNT, v);
        chk("clr", word_t'(v > 0 && v < 16), 16'h0001);
        chk("irq1", 16'(n1 - s1), 16'h0001);
        chk("tog", 16'(nt - st), 16'h0001);
        repeat (300) @(posedge clk_i);
        chk("tog2", 16'(nt - st), 16'h0002);
        chk("irq0", 16'(n0 - s0), 16'h0001);
        $display("done clear");
    endtask
    task automatic t_phase();
        word_t a, v, c;
        int s0, s1, st;
        wreg(`ADDR_PRESCALE, 16'h0000);
        wreg(`ADDR_CAPCTL, 16'h0007);
        wreg(`ADDR_MODE, 16'h0004);
        s0 = n0;
        s1 = n1;
        st = nt;
        rreg(`ADDR_COUNT, a);
        pin(1'b0, 1'b0);
        rreg(`ADDR_CC1, v);
        chk("cc1", near(v, a), 16'h0001);
        rreg(`ADDR_COUNT, a);
        pin(1'b0, 1'b1);
        rreg(`ADDR_CC0, c);
        chk("rev", near(c, a), 16'h0001);
        chk("no irq0", 16'(n0 - s0), 16'h0000);
        chk("irq1", 16'(n1 - s1), 16'h0001);
        // Timer output is left unused while second-input edges are in use
        pin(1'b1, 1'b1);
        pin(1'b1, 1'b0);
        chk("irq0", 16'(n0 - s0), 16'h0001);
        rreg(`ADDR_CC0, v);
        chk("cc0 kept", v, c);
        chk("quiet", 16'(nt - st), 16'h0000);
        $display("done phase");
    endtask
    task automatic t_both();
        word_t a, v, c;
        int s0, s1, st;
        wreg(`ADDR_PRESCALE, 16'h0030);
        wreg(`ADDR_CAPCTL, 16'h0005);
        wreg(`ADDR_MODE, 16'h0006);
        s0 = n0;
        s1 = n1;
        st = nt;
        rreg(`ADDR_CC1, c);
        rreg(`ADDR_COUNT, a);
        pin(1'b1, 1'b1);
        rreg(`ADDR_CC0, v);
        chk("cc0", near(v, a), 16'h0001);
        rreg(`ADDR_CC1, v);
        chk("cc1 kept", v, c);
        chk("irq0", 16'(n0 - s0), 16'h0001);
        pin(1'b0, 1'b0);
        chk("tog", 16'(nt - st), 16'h0001);
        chk("irq1", 16'(n1 - s1), 16'h0001);
        $display("done both");
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_regs();
        t_free();
        t_clear();
        t_phase();
        t_both();
        close_out();
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk_i);
        mismatches++;
        close_out();
    end
endmodule
`default_nettype wire
